// file: common/oame_consts.svh
// Opcode patterns, field positions and reset values for the instruction unit.
// Assumes 12-bit instruction words and an 8-bit data path.
`ifndef OAME_CONSTS_SVH
`define OAME_CONSTS_SVH
`define OAME_OP_OR_LIT      4'hd
`define OAME_OP_LOAD_LIT    4'hc
`define OAME_OP_OR_FILE     6'h04
`define OAME_OP_MOVE_FILE   6'h08
`define OAME_LIT_MSB        7
`define OAME_DEST_BIT       5
`define OAME_ADDR_MSB       4
`define OAME_ACC_RESET      8'h00
`define OAME_ZERO_RESET     1'b0
`endif

// file: common/oame_pkg.sv
// Types shared by the instruction unit.
// Assumes oame_consts.svh for the numeric values.
package oame_pkg;
	typedef enum logic [2:0]
	{
		OAME_NONE      = 3'b000,
		OAME_OR_LIT    = 3'b001,
		OAME_OR_FILE   = 3'b010,
		OAME_MOVE_FILE = 3'b011,
		OAME_LOAD_LIT  = 3'b100
	} oame_op_t;

	typedef struct packed
	{
		logic [7:0] acc;
		logic       zero;
	} oame_state_t;
endpackage

// file: hdl/oame_decode.sv
// Opcode decoder: classifies an instruction word and splits its fields.
// Assumes a valid 12-bit word; purely combinational.
`include "oame_consts.svh"
module oame_decode
	import oame_pkg::*;
(
	input  wire logic [11:0]     instr,     // Instruction word
	output oame_pkg::oame_op_t   op,        // Decoded operation
	output logic [7:0]           literal,   // Literal field
	output logic                 dest_file, // Destination is file register
	output logic [4:0]           faddr      // File address field
);
	always_comb
	begin
		op = OAME_NONE;
		if (instr[11:8] == `OAME_OP_OR_LIT)
			op = OAME_OR_LIT;
		else if (instr[11:8] == `OAME_OP_LOAD_LIT)
			op = OAME_LOAD_LIT;
		else if (instr[11:6] == `OAME_OP_OR_FILE)
			op = OAME_OR_FILE;
		else if (instr[11:6] == `OAME_OP_MOVE_FILE)
			op = OAME_MOVE_FILE;
	end

	assign literal   = instr[`OAME_LIT_MSB:0];
	assign dest_file = instr[`OAME_DEST_BIT];
	assign faddr     = instr[`OAME_ADDR_MSB:0];
endmodule

// file: hdl/oame_exec.sv
// Execution of OR-literal, OR-with-file, move-file and load-literal.
// Assumes the core presents one instruction per cycle with instr_valid and
// serves the file register read combinationally at file_addr.
//
// Behaviour
// [RULE_01] Literal OR: acc OR literal, set zero flag
// [RULE_02] Literal OR writes acc, one cycle
// [RULE_03] File OR: acc OR file, zero flag, one cycle
// [RULE_04] Destination bit 0 acc, 1 file register
// [RULE_05] Move file: copy to destination, zero flag
// [RULE_06] Move destination 0 acc, 1 same file
// [RULE_07] Move with write-back tests register for zero
// [RULE_08] Load literal into acc, flags unchanged
`include "oame_consts.svh"
module oame_exec
	import oame_pkg::*;
#(
	parameter int DATA_W = 8
)
(
	input  wire logic        clk_sys,     // System clock, 20 MHz
	input  wire logic        resetn,      // Asynchronous reset, active low
	input  wire logic        instr_valid, // Instruction present this cycle
	input  wire logic [11:0] instr,       // Instruction word
	input  wire logic [7:0]  file_rdata,  // Data of addressed file register
	output logic [4:0]       file_addr,   // File register address
	output logic             file_we,     // File register write strobe
	output logic [7:0]       file_wdata,  // File register write data
	output logic             handled,     // Instruction belongs to this unit
	output logic [7:0]       acc,         // Working register
	output logic             zero_flag    // Zero status flag
);
	import oame_pkg::*;

	// Fields and the zero test assume one byte of data
	if (DATA_W != 8)
	begin : g_width_check
		$error("oame_exec supports only an 8-bit data path");
	end

	// Decoder fields
	oame_op_t    op;
	logic [7:0]  literal;
	logic        dest_file;
	logic [4:0]  faddr;

	// Working values and state
	logic [7:0]  result;
	logic        exec_now;
	oame_state_t st_ff;
	oame_state_t nxt_st;

	// Decoder
	oame_decode u_decode
	(
		.instr     (instr),
		.op        (op),
		.literal   (literal),
		.dest_file (dest_file),
		.faddr     (faddr)
	);

	// True when every bit of a byte is clear
	function automatic logic is_zero
	(
		input logic [7:0] v
	);
		return v == 8'h00;
	endfunction

	// Inclusive OR of two bytes
	function automatic logic [7:0] or_bytes
	(
		input logic [7:0] a,
		input logic [7:0] b
	);
		return a | b;
	endfunction

	// Operations that this unit claims
	function automatic logic is_own_op
	(
		input oame_op_t o
	);
		logic own;
		own = 1'b0;
		case (o)
			OAME_OR_LIT:    own = 1'b1;
			OAME_OR_FILE:   own = 1'b1;
			OAME_MOVE_FILE: own = 1'b1;
			OAME_LOAD_LIT:  own = 1'b1;
			default:        own = 1'b0;
		endcase
		return own;
	endfunction

	// Operations whose result may go back to the file register
	function automatic logic has_file_dest
	(
		input oame_op_t o
	);
		logic fd;
		fd = 1'b0;
		case (o)
			OAME_OR_FILE:   fd = 1'b1;
			OAME_MOVE_FILE: fd = 1'b1;
			default:        fd = 1'b0;
		endcase
		return fd;
	endfunction

	// Operations that report a zero result in the flag
	function automatic logic sets_zero
	(
		input oame_op_t o
	);
		logic sz;
		sz = 1'b0;
		case (o)
			OAME_OR_LIT:    sz = 1'b1;
			OAME_OR_FILE:   sz = 1'b1;
			OAME_MOVE_FILE: sz = 1'b1;
			default:        sz = 1'b0;
		endcase
		return sz;
	endfunction

	// Acc after a file operation: kept when the result goes to the file
	function automatic logic [7:0] pick_acc
	(
		input logic       dest,
		input logic [7:0] old_acc,
		input logic [7:0] res
	);
		return dest ? old_acc : res;
	endfunction

	// Value produced by an operation, before it is routed
	function automatic logic [7:0] op_result
	(
		input oame_op_t   o,
		input logic [7:0] w,
		input logic [7:0] lit,
		input logic [7:0] fdat
	);
		logic [7:0] r;
		r = 8'h00;
		case (o)
			OAME_OR_LIT:    r = or_bytes(w, lit);  // see [RULE_01]
			OAME_OR_FILE:   r = or_bytes(w, fdat); // see [RULE_03]
			OAME_MOVE_FILE: r = fdat;              // see [RULE_05]
			OAME_LOAD_LIT:  r = lit;               // see [RULE_08]
			default:        r = 8'h00;
		endcase
		return r;
	endfunction

	// Foreign words and idle cycles leave everything untouched
	assign exec_now = instr_valid && is_own_op(op);

	// One process computes the whole next state; the handshake outputs
	// follow the instruction within the cycle
	always_comb
	begin
		nxt_st  = st_ff;
		result  = 8'h00;
		file_we = 1'b0;
		handled = exec_now;
		if (exec_now)
		begin
			result = op_result(op, st_ff.acc, literal, file_rdata);
			if (sets_zero(op))
			begin
				nxt_st.zero = is_zero(result); // see [RULE_01] [RULE_03] [RULE_07]
			end

			case (op)
				OAME_OR_LIT:
				begin
					// Result goes to acc only; the file port stays quiet
					nxt_st.acc = result; // see [RULE_02]
				end
				OAME_OR_FILE:
				begin
					nxt_st.acc = pick_acc(dest_file, st_ff.acc, result); // see [RULE_04]
					file_we    = dest_file && has_file_dest(op);         // see [RULE_04]
				end
				OAME_MOVE_FILE:
				begin
					// Rewriting the same value leaves the register intact
					nxt_st.acc = pick_acc(dest_file, st_ff.acc, result); // see [RULE_06]
					file_we    = dest_file && has_file_dest(op);         // see [RULE_06]
				end
				OAME_LOAD_LIT:
				begin
					// Flags stay as they were
					nxt_st.acc = literal; // see [RULE_08]
				end
				default:
				begin
					nxt_st = st_ff;
				end
			endcase
		end
	end

	// Reset clears acc and the zero flag
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			st_ff.acc  <= `OAME_ACC_RESET;
			st_ff.zero <= `OAME_ZERO_RESET;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	// File port follows the word; status comes from the state
	assign file_addr  = faddr;
	assign file_wdata = result;
	assign acc        = st_ff.acc;
	assign zero_flag  = st_ff.zero;
endmodule

// file: bench/oame_exec_props.sv
// Port checker for the instruction unit.
// Bound to oame_exec; one clock domain.
module oame_exec_props
(
	input logic        clk_sys,
	input logic        resetn,
	input logic        instr_valid,
	input logic [11:0] instr,
	input logic [7:0]  file_rdata,
	input logic        file_we,
	input logic [7:0]  file_wdata,
	input logic        handled,
	input logic [7:0]  acc,
	input logic        zero_flag
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);
	wire orl = instr_valid && instr[11:8] == 4'hd;
	wire ldl = instr_valid && instr[11:8] == 4'hc;
	wire orf = instr_valid && instr[11:6] == 6'h04;
	wire mvf = instr_valid && instr[11:6] == 6'h08;
	a_orl_acc: assert property
		(orl |=> acc == ($past(acc) | $past(instr[7:0])) && zero_flag == (acc == 0))
		else $error("or literal result");
	a_orl_only: assert property (orl |-> handled && !file_we)
		else $error("or literal target");
	a_orf_out: assert property
		(orf |-> handled && file_we == instr[5] && file_wdata == (acc | file_rdata))
		else $error("or file output");
	a_orf_res: assert property
		(orf |=> zero_flag == (($past(acc) | $past(file_rdata)) == 0)
		&& acc == ($past(instr[5]) ? $past(acc) : $past(acc) | $past(file_rdata)))
		else $error("or file result");
	a_mvf_out: assert property
		(mvf |-> handled && file_we == instr[5] && file_wdata == file_rdata)
		else $error("move output");
	a_mvf_res: assert property
		(mvf |=> zero_flag == ($past(file_rdata) == 0)
		&& acc == ($past(instr[5]) ? $past(acc) : $past(file_rdata)))
		else $error("move result");
	a_ldl_acc: assert property
		(ldl |=> acc == $past(instr[7:0]) && $stable(zero_flag))
		else $error("load literal");
	a_other_idle: assert property (!(orl || ldl || orf || mvf) |-> !handled && !file_we)
		else $error("foreign word taken");
endmodule
bind oame_exec oame_exec_props u_oame_exec_props (.clk_sys, .resetn, .instr_valid, .instr,
	.file_rdata, .file_we, .file_wdata, .handled, .acc, .zero_flag);

// file: bench/tb.sv
// Self-checking bench for the instruction unit.
// Bench serves file reads itself.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import oame_pkg::*;
	logic clk_sys = 0, resetn = 0, instr_valid = 0, file_we, handled, zero_flag;
	logic [11:0] instr = 0;
	logic [7:0] file_rdata = 0, file_wdata, acc;
	logic [4:0] file_addr;
	int bad_count = 0, n_checks = 0;
	oame_exec u_oame_exec (.clk_sys, .resetn, .instr_valid, .instr, .file_rdata,
		.file_addr, .file_we, .file_wdata, .handled, .acc, .zero_flag);
	initial forever #25 clk_sys = ~clk_sys;
	task chk(input logic c);
		n_checks++;
		if (c !== 1'b1)
		begin
			bad_count++;
			$display("mismatch %0t value wrong", $time);
		end
	endtask
	// Issue one word, check same-cycle outputs, then registered state
	task run(input logic v, input logic [11:0] i, input logic [7:0] r, input logic w,
		input logic [7:0] d, input logic h, input logic [7:0] a, input logic z);
		@(posedge clk_sys);
		#1 instr_valid = v;
		instr = i;
		file_rdata = r;
		#1 chk(file_we === w && (!w || file_wdata === d) && file_addr === i[4:0]);
		chk(handled === h);
		@(posedge clk_sys);
		#1 instr_valid = 0;
		chk(acc === a && zero_flag === z);
	endtask
	task t_literal;
		run(1, 12'hc9a, 0, 0, 0, 1, 8'h9a, 0);
		run(1, 12'hd35, 0, 0, 0, 1, 8'hbf, 0);
		run(1, 12'hc00, 0, 0, 0, 1, 8'h00, 0);
		run(1, 12'hd00, 0, 0, 0, 1, 8'h00, 1);
		run(1, 12'hc5a, 0, 0, 0, 1, 8'h5a, 1);
	endtask
	task t_file;
		run(1, 12'h13f, 8'h13, 1, 8'h5b, 1, 8'h5a, 0);
		run(1, 12'h11f, 8'h81, 0, 0, 1, 8'hdb, 0);
		run(1, 12'h23f, 8'h00, 1, 8'h00, 1, 8'hdb, 1);
		run(1, 12'h205, 8'h44, 0, 0, 1, 8'h44, 0);
		run(1, 12'h2bf, 8'h00, 0, 0, 0, 8'h44, 0);
		run(0, 12'h23f, 8'h00, 0, 0, 0, 8'h44, 0);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		#100000 bad_count++;
		print_verdict;
	end
	initial
	begin
		repeat (6) @(posedge clk_sys);
		#1 resetn = 1;
		t_literal;
		t_file;
		print_verdict;
	end
endmodule
